// *** lvds_pixel_link_receiver.sv ***
// Serial pixel link receiver: deserialiser, clock crossing, pixel output
`timescale 1ns/1ps
module lvds_pixel_link_receiver #(
    parameter int WIDE = 1,
    parameter int LOCK_WORDS = lvds_rx_pkg::LOCK_WORDS_DEF,
    parameter int DEPTH = lvds_rx_pkg::BUF_DEPTH_DEF,
    parameter int PLL_SET_CYC = lvds_rx_pkg::PLL_SET_CYC,
    parameter int LANES = (WIDE != 0) ? lvds_rx_pkg::LANES_WIDE
                                      : lvds_rx_pkg::LANES_NARROW,
    parameter int BITS = LANES * lvds_rx_pkg::BITS_PER_LANE
) (
    // System clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Link pins
    input wire logic link_clk,
    input wire logic link_clock_pair,
    input wire logic [LANES-1:0] serial_data_lanes,
    input wire logic sleep_n,
    // Panel side
    input wire logic panel_hold,
    output logic recovered_pixel_clock,
    output logic [BITS-1:0] pixel_out_bus,
    output lvds_rx_pkg::pix_ctrl_s sync_out,
    // Status
    output logic link_locked,
    output logic link_overrun
);

    // ********************************
    // Local sizes
    // ********************************
    localparam int COLOR = (WIDE != 0) ? lvds_rx_pkg::COLOR_WIDE
                                       : lvds_rx_pkg::COLOR_NARROW;
    localparam int SYNC_BASE = 3 * COLOR;
    localparam int AW = $clog2(DEPTH);
    localparam int LCW = $clog2(LOCK_WORDS + 1);
    localparam logic [LCW-1:0] LOCK_FULL = LCW'(LOCK_WORDS);
    localparam logic [2:0] HIGH_LAST = 3'(lvds_rx_pkg::HIGH_CYC - 1);
    localparam logic [2:0] LOW_LAST = 3'(lvds_rx_pkg::LOW_CYC - 1);
    localparam int PD_MAX = lvds_rx_pkg::PD_CYC;
    localparam int W = lvds_rx_pkg::BITS_PER_LANE;

    // Gray to binary conversion of buffer pointers
    function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
        logic [AW:0] b;
        b[AW] = g[AW];
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    // ********************************
    // Link domain synchronisers
    // ********************************
    localparam logic [7:0] RST_LAST = 8'(lvds_rx_pkg::LINK_RST_CYC - 1);
    logic [7:0] rst_cnt_reg;
    logic link_rst_req_reg;
    logic rst_meta_reg, link_rst_n;
    logic sleep_l_meta_reg, awake_link_reg;

    // Reset stretched so a short pulse still reaches the slow link clock
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rst_cnt_reg <= 8'h00;
            link_rst_req_reg <= 1'b0;
        end else if (rst_cnt_reg != RST_LAST) begin
            rst_cnt_reg <= rst_cnt_reg + 8'h01;
        end else begin
            link_rst_req_reg <= 1'b1;
        end
    end

    // Reset and sleep brought onto the link clock
    always_ff @(posedge link_clk) begin
        rst_meta_reg <= link_rst_req_reg;
        link_rst_n <= rst_meta_reg;
        sleep_l_meta_reg <= sleep_n;
        awake_link_reg <= sleep_l_meta_reg;
    end

    // ********************************
    // Deserialiser
    // ********************************
    logic [W-1:0] clk_shift_reg;
    logic [W-1:0] lane_shift_reg [LANES];
    logic [BITS-1:0] lane_word;
    logic [2:0] bit_cnt_reg;
    logic [LCW-1:0] lock_cnt_reg;
    logic locked_reg;
    logic word_tick;

    // One shifter per lane, first bit ends at position 0
    genvar ln;
    generate
        for (ln = 0; ln < LANES; ln++) begin : g_lane
            always_ff @(posedge link_clk) begin
                lane_shift_reg[ln] <= {serial_data_lanes[ln],
                                       lane_shift_reg[ln][W-1:1]};
            end
            assign lane_word[ln*W +: W] = lane_shift_reg[ln];
        end
    endgenerate

    // Clock lane shifter shows the word boundary pattern
    always_ff @(posedge link_clk) begin
        clk_shift_reg <= {link_clock_pair, clk_shift_reg[W-1:1]};
    end

    assign word_tick = (clk_shift_reg == lvds_rx_pkg::CLK_PATTERN);

    // Strobe position counter, bit 0 through bit 6
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            bit_cnt_reg <= 3'h0;
        end else if (word_tick || bit_cnt_reg == lvds_rx_pkg::LAST_BIT) begin
            bit_cnt_reg <= 3'h0;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
    end

    // Lock after enough boundaries seven bits apart
    always_ff @(posedge link_clk) begin
        if (!link_rst_n || !awake_link_reg) begin
            lock_cnt_reg <= '0;
        end else if (word_tick && bit_cnt_reg != lvds_rx_pkg::LAST_BIT) begin
            lock_cnt_reg <= '0;
        end else if (!word_tick && bit_cnt_reg == lvds_rx_pkg::LAST_BIT) begin
            lock_cnt_reg <= '0;
        end else if (word_tick && lock_cnt_reg != LOCK_FULL) begin
            lock_cnt_reg <= lock_cnt_reg + LCW'(1);
        end
    end

    // Locked state as a flop for the crossing
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            locked_reg <= 1'b0;
        end else begin
            locked_reg <= awake_link_reg && (lock_cnt_reg == LOCK_FULL);
        end
    end

    // ********************************
    // Two-entry crossing buffer
    // ********************************
    logic [BITS-1:0] mem [DEPTH];
    logic [AW:0] wbin_reg, wgray_reg, rbin_reg, rgray_reg;
    logic [AW:0] rg_meta_reg, rg_sync_reg, wg_meta_reg, wg_sync_reg;
    logic [AW:0] rbin_seen;
    logic [AW-1:0] wr_addr;
    logic full_w, push, empty_r;

    assign rbin_seen = gray2bin(rg_sync_reg);
    assign wr_addr = wbin_reg[AW-1:0];
    assign full_w = (wbin_reg[AW] != rbin_seen[AW]) &&
                    (wbin_reg[AW-1:0] == rbin_seen[AW-1:0]);
    assign push = word_tick && locked_reg && awake_link_reg && !full_w;

    // Read pointer brought onto the link clock
    always_ff @(posedge link_clk) begin
        rg_meta_reg <= rgray_reg;
        rg_sync_reg <= rg_meta_reg;
    end

    // Write side of the buffer
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            wbin_reg <= '0;
            wgray_reg <= '0;
        end else if (push) begin
            wbin_reg <= wbin_reg + (AW+1)'(1);
            wgray_reg <= (wbin_reg + (AW+1)'(1)) ^
                         ((wbin_reg + (AW+1)'(1)) >> 1);
        end
    end

    // Buffer storage, written on the link clock only
    always_ff @(posedge link_clk) begin
        if (push) begin
            mem[wr_addr] <= lane_word;
        end
    end

    // Word lost while the buffer is full
    always_ff @(posedge link_clk) begin
        if (!link_rst_n || !awake_link_reg) begin
            link_overrun <= 1'b0;
        end else if (word_tick && locked_reg && full_w) begin
            link_overrun <= 1'b1;
        end
    end

    // ********************************
    // System domain synchronisers
    // ********************************
    logic sleep_meta_reg, sleep_sys_reg, lock_meta_reg, lock_sync_reg;
    logic en;

    // Sleep pin and lock level onto the system clock
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sleep_meta_reg <= 1'b0;
            sleep_sys_reg <= 1'b0;
            lock_meta_reg <= 1'b0;
            lock_sync_reg <= 1'b0;
        end else begin
            sleep_meta_reg <= sleep_n;
            sleep_sys_reg <= sleep_meta_reg;
            lock_meta_reg <= locked_reg;
            lock_sync_reg <= lock_meta_reg;
        end
    end

    assign en = sleep_sys_reg && lock_sync_reg;

    // Write pointer brought onto the system clock
    always_ff @(posedge sys_clk) begin
        wg_meta_reg <= wgray_reg;
        wg_sync_reg <= wg_meta_reg;
    end

    // ********************************
    // Pixel output
    // ********************************
    lvds_rx_pkg::out_state_e state_reg;
    logic [2:0] phase_cnt_reg;
    logic [BITS-1:0] rd_word;
    logic ready_out, pop, pop_go;
    logic [31:0] wait_cnt_reg;

    assign empty_r = (rgray_reg == wg_sync_reg);
    assign rd_word = mem[rbin_reg[AW-1:0]];
    assign ready_out = (state_reg == lvds_rx_pkg::OUT_IDLE) ||
                       (state_reg == lvds_rx_pkg::OUT_LOW &&
                        phase_cnt_reg == 3'h0);
    assign pop_go = !empty_r && en && ready_out && !panel_hold;
    assign pop = pop_go || (!empty_r && !en);

    // Read side of the buffer, stale words dropped while disabled
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rbin_reg <= '0;
            rgray_reg <= '0;
        end else if (pop) begin
            rbin_reg <= rbin_reg + (AW+1)'(1);
            rgray_reg <= (rbin_reg + (AW+1)'(1)) ^
                         ((rbin_reg + (AW+1)'(1)) >> 1);
        end
    end

    // Clock shaper: high phase then low phase per word
    always_ff @(posedge sys_clk) begin
        if (!nrst || !en) begin
            state_reg <= lvds_rx_pkg::OUT_IDLE;
            phase_cnt_reg <= 3'h0;
            recovered_pixel_clock <= 1'b0;
        end else begin
            unique case (state_reg)
                lvds_rx_pkg::OUT_IDLE, lvds_rx_pkg::OUT_LOW: begin
                    if (pop_go) begin
                        state_reg <= lvds_rx_pkg::OUT_HIGH;
                        phase_cnt_reg <= HIGH_LAST;
                        recovered_pixel_clock <= 1'b1;
                    end else if (phase_cnt_reg != 3'h0) begin
                        phase_cnt_reg <= phase_cnt_reg - 3'h1;
                    end else begin
                        state_reg <= lvds_rx_pkg::OUT_IDLE;
                    end
                end
                lvds_rx_pkg::OUT_HIGH: begin
                    if (phase_cnt_reg != 3'h0) begin
                        phase_cnt_reg <= phase_cnt_reg - 3'h1;
                    end else begin
                        state_reg <= lvds_rx_pkg::OUT_LOW;
                        phase_cnt_reg <= LOW_LAST;
                        recovered_pixel_clock <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= lvds_rx_pkg::OUT_IDLE;
                end
            endcase
        end
    end

    // Pixel word and control lines change on the rising edge
    always_ff @(posedge sys_clk) begin
        if (!nrst || !en) begin
            pixel_out_bus <= '0;
            sync_out <= '0;
        end else if (pop_go) begin
            pixel_out_bus <= rd_word;
            sync_out.line_sync <= rd_word[SYNC_BASE +
                                          lvds_rx_pkg::LINE_OFS];
            sync_out.frame_sync <= rd_word[SYNC_BASE +
                                           lvds_rx_pkg::FRAME_OFS];
            sync_out.pixel_valid <= rd_word[SYNC_BASE +
                                            lvds_rx_pkg::VALID_OFS];
        end
    end

    // Lock status and wait since wake
    always_ff @(posedge sys_clk) begin
        if (!nrst || !sleep_sys_reg) begin
            link_locked <= 1'b0;
            wait_cnt_reg <= 32'h0;
        end else begin
            link_locked <= lock_sync_reg;
            if (!lock_sync_reg) begin
                wait_cnt_reg <= wait_cnt_reg + 32'h1;
            end
        end
    end

    // ********************************
    // Assertions
    // ********************************
    sequence load_s;
        pop_go;
    endsequence

    sequence strobe_s;
        recovered_pixel_clock
        ##1 (recovered_pixel_clock && $stable(pixel_out_bus))
        ##1 (!recovered_pixel_clock && $stable(pixel_out_bus));
    endsequence

    strobe_edge_a: assert property (
        @(posedge sys_clk) disable iff (!nrst || !en)
        load_s |=> strobe_s)
        else $error("data not stable across falling clock edge");

    sleep_low_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !sleep_sys_reg |=> (!recovered_pixel_clock &&
                            pixel_out_bus == '0 && sync_out == '0))
        else $error("outputs not low in sleep");

    ctrl_map_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        sync_out == {pixel_out_bus[SYNC_BASE + lvds_rx_pkg::LINE_OFS],
                     pixel_out_bus[SYNC_BASE + lvds_rx_pkg::FRAME_OFS],
                     pixel_out_bus[SYNC_BASE + lvds_rx_pkg::VALID_OFS]})
        else $error("control lines disagree with pixel word");

    lock_time_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        wait_cnt_reg < 32'(PLL_SET_CYC))
        else $error("lock not reached in time");

    sleep_delay_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        $fell(sleep_n) |-> ##[1:PD_MAX]
            (!recovered_pixel_clock && pixel_out_bus == '0))
        else $error("sleep state not reached in time");

    clock_period_a: assert property (
        @(posedge sys_clk) disable iff (!nrst || !en)
        $rose(recovered_pixel_clock) |->
            recovered_pixel_clock[*2] ##1 !recovered_pixel_clock[*2])
        else $error("output clock phase too short");

    word_write_a: assert property (
        @(posedge link_clk) disable iff (!link_rst_n)
        push |=> mem[$past(wr_addr)] == $past(lane_word))
        else $error("deserialised word not stored");

    bit_strobe_a: assert property (
        @(posedge link_clk) disable iff (!link_rst_n || !awake_link_reg)
        (word_tick && locked_reg) |->
            bit_cnt_reg == lvds_rx_pkg::LAST_BIT ##1 !word_tick[*6])
        else $error("word boundary not seven strobes apart");

    unaligned_a: assert property (
        @(posedge sys_clk) disable iff (!nrst)
        !lock_sync_reg |=> (!recovered_pixel_clock && pixel_out_bus == '0))
        else $error("outputs active before lock");

endmodule // lvds_pixel_link_receiver

// *** lvds_rx_pkg.sv ***
// Constants, types and timing figures for the serial pixel link receiver
package lvds_rx_pkg;

    // ********************************
    // Link framing
    // ********************************
    localparam int BITS_PER_LANE = 7;
    localparam logic [2:0] LAST_BIT = 3'h6;
    localparam logic [6:0] CLK_PATTERN = 7'h63;
    localparam int LANES_WIDE = 4;
    localparam int LANES_NARROW = 3;
    localparam int COLOR_WIDE = 8;
    localparam int COLOR_NARROW = 6;
    localparam int CTRL_LINES = 3;
    localparam int LINE_OFS = 0;
    localparam int FRAME_OFS = 1;
    localparam int VALID_OFS = 2;
    localparam int LOCK_WORDS_DEF = 8;
    localparam int BUF_DEPTH_DEF = 2;

    // ********************************
    // Timing
    // ********************************
    localparam int SYS_CLK_PS = 4000;
    localparam int RCOH_MIN_PS = 5000;
    localparam int RCOL_MIN_PS = 5000;
    localparam int RCOP_MIN_PS = 15000;
    localparam int RCOP_MAX_PS = 50000;
    localparam int HIGH_CYC = (RCOH_MIN_PS + SYS_CLK_PS - 1) / SYS_CLK_PS;
    localparam int LOW_CYC = (RCOL_MIN_PS + SYS_CLK_PS - 1) / SYS_CLK_PS;
    localparam int RPDD_US = 1;
    localparam int PS_PER_US = 1000000;
    localparam int PD_CYC = RPDD_US * PS_PER_US / SYS_CLK_PS;
    localparam int RPLLS_MS = 10;
    localparam int PS_PER_MS = 1000000000;
    localparam int PLL_SET_CYC = RPLLS_MS * (PS_PER_MS / SYS_CLK_PS);
    localparam int LINK_RST_CYC = 128;

    // ********************************
    // Types
    // ********************************
    typedef struct packed {
        logic line_sync;
        logic frame_sync;
        logic pixel_valid;
    } pix_ctrl_s;

    typedef enum logic [1:0] {
        OUT_IDLE = 2'b00,
        OUT_HIGH = 2'b01,
        OUT_LOW = 2'b10
    } out_state_e;

endpackage

// *** pixel_link_tx.sv ***
// Behavioural serialiser standing on the far side of the pixel link
`timescale 1ns/1ps
module pixel_link_tx #(
    parameter int LANES = 4
) (
    // Link bit clock
    input wire logic link_clk,
    // Link pins
    output logic link_clock_pair,
    output logic [LANES-1:0] serial_data_lanes
);
    logic [LANES*7-1:0] pend_q[$];
    logic [LANES*7-1:0] cur_word;
    int pos;

    // Queue a word for transmission; idle slots carry an all-zero word
    task automatic load(input logic [LANES*7-1:0] w);
        pend_q.push_back(w);
    endtask

    initial begin
        cur_word = '0;
        pos = 0;
        link_clock_pair = 1'b0;
        serial_data_lanes = '0;
    end

    // Stream runs without gaps so the receiver never loses alignment
    always @(posedge link_clk) begin
        if (pos == 0) begin
            cur_word = (pend_q.size() != 0) ? pend_q.pop_front() : '0;
        end
        link_clock_pair <= lvds_rx_pkg::CLK_PATTERN[pos];
        for (int l = 0; l < LANES; l++) begin
            serial_data_lanes[l] <= cur_word[7*l+pos];
        end
        pos = (pos == 6) ? 0 : pos + 1;
    end
endmodule // pixel_link_tx

// *** tb_lvds_pixel_link_receiver.sv ***
// Self-checking bench for the serial pixel link receiver
`timescale 1ns/1ps
module tb_lvds_pixel_link_receiver;
    localparam int BITS = 28;
    localparam int C = lvds_rx_pkg::COLOR_WIDE;
    localparam int NB = 21;
    localparam int CN = lvds_rx_pkg::COLOR_NARROW;
    logic sys_clk;
    logic nrst;
    logic link_clk;
    logic sleep_n;
    logic panel_hold;
    logic link_clock_pair;
    logic [3:0] serial_data_lanes;
    logic recovered_pixel_clock;
    logic [BITS-1:0] pixel_out_bus;
    lvds_rx_pkg::pix_ctrl_s sync_out;
    logic link_locked;
    logic link_overrun;
    logic n_pix_clk;
    logic [NB-1:0] n_pix_bus;
    lvds_rx_pkg::pix_ctrl_s n_sync;
    logic n_locked;
    logic n_overrun;
    logic [BITS-1:0] exp_q[$];
    logic [BITS-1:0] w;
    logic [NB-1:0] nexp_q[$];
    logic [NB-1:0] nw;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    realtime t_rise = 0.0;

    // ********************************
    // Clocks, design and partner
    // ********************************
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        link_clk = 1'b0;
        #13;
        forever #40 link_clk = ~link_clk;
    end
    lvds_pixel_link_receiver #(.LOCK_WORDS(2), .PLL_SET_CYC(2000))
        lvds_pixel_link_receiver_inst (
        .sys_clk(sys_clk), .nrst(nrst), .link_clk(link_clk),
        .link_clock_pair(link_clock_pair),
        .serial_data_lanes(serial_data_lanes), .sleep_n(sleep_n),
        .panel_hold(panel_hold),
        .recovered_pixel_clock(recovered_pixel_clock),
        .pixel_out_bus(pixel_out_bus), .sync_out(sync_out),
        .link_locked(link_locked), .link_overrun(link_overrun));
    // Narrow variant listens to the first three lanes of the same stream
    lvds_pixel_link_receiver #(.WIDE(0), .LOCK_WORDS(2))
        narrow_lvds_pixel_link_receiver_inst (
        .sys_clk(sys_clk), .nrst(nrst), .link_clk(link_clk),
        .link_clock_pair(link_clock_pair),
        .serial_data_lanes(serial_data_lanes[2:0]), .sleep_n(sleep_n),
        .panel_hold(panel_hold), .recovered_pixel_clock(n_pix_clk),
        .pixel_out_bus(n_pix_bus), .sync_out(n_sync),
        .link_locked(n_locked), .link_overrun(n_overrun));
    pixel_link_tx pixel_link_tx_inst (
        .link_clk(link_clk), .link_clock_pair(link_clock_pair),
        .serial_data_lanes(serial_data_lanes));

    // ********************************
    // Checking and closing
    // ********************************
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Cut a hang short
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            final_report();
        end
    end

    // Rising clock: period never below the minimum
    always @(posedge recovered_pixel_clock) begin
        if (t_rise > 0.0) begin
            check("clk_period", 32'($realtime - t_rise >= 15.0), 1);
        end
        t_rise = $realtime;
    end

    // Falling clock is the strobe: compare against the oldest note
    always @(negedge recovered_pixel_clock) begin
        if (sleep_n) begin
            check("clk_high", 32'($realtime - t_rise >= 5.0), 1);
        end
        if (nrst && pixel_out_bus !== '0) begin
            if (exp_q.size() == 0) begin
                check("unexpected_word", 32'(pixel_out_bus), 0);
            end else begin
                w = exp_q.pop_front();
                check("pixel_word", 32'(pixel_out_bus), 32'(w));
                check("sync_lines", 32'(sync_out),
                      {29'h0, w[3*C], w[3*C+1], w[3*C+2]});
            end
        end
    end

    // Narrow variant strobe: same notes cut to its word width
    always @(negedge n_pix_clk) begin
        if (nrst && n_pix_bus !== '0) begin
            if (nexp_q.size() == 0) begin
                check("n_unexpected", 32'(n_pix_bus), 0);
            end else begin
                nw = nexp_q.pop_front();
                check("n_pixel_word", 32'(n_pix_bus), 32'(nw));
                check("n_sync_lines", 32'(n_sync),
                      {29'h0, nw[3*CN], nw[3*CN+1], nw[3*CN+2]});
            end
        end
    end

    // ********************************
    // Stimulus helpers
    // ********************************
    task automatic send(input int n);
        logic [BITS-1:0] v;
        for (int i = 0; i < n; i++) begin
            v = BITS'($urandom()) | 28'h0000001;
            exp_q.push_back(v);
            nexp_q.push_back(v[NB-1:0]);
            pixel_link_tx_inst.load(v);
        end
    endtask

    task automatic wait_size(input int n, input int limit);
        int k;
        k = 0;
        while (exp_q.size() > n && k < limit) begin
            @(posedge sys_clk);
            k++;
        end
        check("drain", exp_q.size(), n);
        check("n_drain", nexp_q.size(), n);
    endtask

    task automatic wait_lock();
        int k;
        k = 0;
        while ((link_locked & n_locked) !== 1'b1 && k < 2000) begin
            check("held_low", 32'(pixel_out_bus), 0);
            check("n_held_low", 32'(n_pix_bus), 0);
            @(posedge sys_clk);
            k++;
        end
        check("locked", 32'(link_locked), 1);
        check("n_locked", 32'(n_locked), 1);
    endtask

    task automatic check_quiet();
        check("pd_data", 32'(pixel_out_bus), 0);
        check("pd_clk", 32'(recovered_pixel_clock), 0);
        check("pd_sync", 32'(sync_out), 0);
        check("pd_lock", 32'(link_locked), 0);
        check("n_pd_data", 32'(n_pix_bus), 0);
        check("n_pd_clk", 32'(n_pix_clk), 0);
        check("n_pd_sync", 32'(n_sync), 0);
        check("n_pd_lock", 32'(n_locked), 0);
    endtask

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        nrst <= 1'b0;
        sleep_n <= 1'b0;
        panel_hold <= 1'b0;
        void'($urandom(1949));
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (100) @(posedge sys_clk);
        check_quiet();
        check("pd_ovr", 32'(link_overrun), 0);
        check("n_pd_ovr", 32'(n_overrun), 0);
        sleep_n <= 1'b1;
        wait_lock();
        // Back-to-back words, random content
        send(12);
        wait_size(0, 3000);
        // Panel stall: two words buffered, the rest overrun
        send(5);
        wait_size(4, 400);
        panel_hold <= 1'b1;
        repeat (900) @(posedge sys_clk);
        check("overrun", 32'(link_overrun), 1);
        check("n_overrun", 32'(n_overrun), 1);
        exp_q.delete(3);
        exp_q.delete(2);
        nexp_q.delete(3);
        nexp_q.delete(2);
        panel_hold <= 1'b0;
        wait_size(0, 400);
        // Power-down mid-stream discards and clears all
        send(3);
        repeat (20) @(posedge sys_clk);
        sleep_n <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check_quiet();
        repeat (60) @(posedge sys_clk);
        check("pd_ovr_clr", 32'(link_overrun), 0);
        check("n_pd_ovr_clr", 32'(n_overrun), 0);
        repeat (500) @(posedge sys_clk);
        exp_q.delete();
        nexp_q.delete();
        sleep_n <= 1'b1;
        wait_lock();
        send(8);
        wait_size(0, 2000);
        final_report();
    end
endmodule // tb_lvds_pixel_link_receiver
